// *** hdl/msl_config_bank.v ***
// Configuration bank, packet filter, power timing and idle timeout of the modem.
// Assumes the command parser delivers decoded register writes and command pulses
// synchronous to ref_clk; all inputs but the asynchronous reset rst_b are synchronous.
`timescale 1ns/1ps
`include "msl_consts.vh"

module msl_config_bank
#(
  parameter MS_CYCLES = `MSL_CYC_PER_MS
)
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Register access from the command parser
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regIndex,
  input  wire [7:0]  regWrData,
  output reg  [7:0]  regRdData,
  output reg         writeOk,
  output reg         errorResponse,
  // Host commands
  input  wire        standbyEnableCommand,
  input  wire        standbyReleaseCommand,
  input  wire        restartCommand,
  input  wire        powerDownReturn,
  // Received radio packet
  input  wire        pktValid,
  input  wire        pktDestMatch,
  input  wire        pktGroupMatch,
  input  wire        pktBroadcast,
  input  wire        ackSent,
  output reg         pktAccept,
  output reg         pktAck,
  // Serial framing
  output reg         dataBits7,
  output reg         parityEnable,
  output reg         parityOdd,
  output reg         stopBits2,
  output reg  [15:0] baudDivisor,
  output reg         flowControlEnable,
  // Headerless mode
  input  wire        hostByteIn,
  input  wire        txBufNonEmpty,
  output reg         headerlessMode,
  output reg         appendCrLf,
  output reg         delimCrLf,
  output reg         idleFlush,
  // Power state
  output reg         inStandby,
  output reg         inSleep
);

  //--------------------------------------------------------------------
  // Constants
  //--------------------------------------------------------------------
  // Full-width quotients first, then cut to the 16-bit counters on purpose
  localparam [31:0] MS_WIDE  = MS_CYCLES - 1;
  localparam [31:0] DIVW0    = `MSL_CLK_HZ / `MSL_BAUD0;
  localparam [31:0] DIVW1    = `MSL_CLK_HZ / `MSL_BAUD1;
  localparam [31:0] DIVW2    = `MSL_CLK_HZ / `MSL_BAUD2;
  localparam [31:0] DIVW3    = `MSL_CLK_HZ / `MSL_BAUD3;
  localparam [15:0] MS_LAST  = MS_WIDE[15:0];
  localparam [15:0] DIV0     = DIVW0[15:0];
  localparam [15:0] DIV1     = DIVW1[15:0];
  localparam [15:0] DIV2     = DIVW2[15:0];
  localparam [15:0] DIV3     = DIVW3[15:0];
  localparam [1:0]  ST_AWAKE = 2'h0;
  localparam [1:0]  ST_STBY  = 2'h1;
  localparam [1:0]  ST_SLEEP = 2'h2;

  //--------------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------------
  reg  [7:0]  modeReg;
  reg  [7:0]  addrReg;
  reg  [7:0]  frameReg;
  reg  [7:0]  flowReg;
  reg  [7:0]  stbyReg;
  reg  [7:0]  lineReg;
  reg  [7:0]  delimReg;
  reg  [7:0]  sleepReg;
  reg  [7:0]  timeoutReg;

  // Range check; unknown numbers are refused as well
  function writeValid;
    input [7:0] idx;
    input [7:0] val;
    begin
      case (idx)
        `MSL_IDX_MODE:    writeValid = (val == `MSL_MODE_PACKET) ||
                                       (val == `MSL_MODE_HDRLESS);
        `MSL_IDX_STBY:    writeValid = (val != 8'h00);
        `MSL_IDX_SLEEP:   writeValid = (val != 8'h00);
        `MSL_IDX_TIMEOUT: writeValid = (val != 8'h00);
        `MSL_IDX_ADDR,
        `MSL_IDX_FRAME,
        `MSL_IDX_FLOW,
        `MSL_IDX_LINE,
        `MSL_IDX_DELIM:   writeValid = 1'b1;
        default:          writeValid = 1'b0;
      endcase
    end
  endfunction

  wire        wrGood = regWrite && writeValid(regIndex, regWrData);

  // Storage keeps defaults until a good write; refused writes leave it intact
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeReg    <= `MSL_RST_MODE;
      addrReg    <= `MSL_RST_ADDR;
      frameReg   <= `MSL_RST_FRAME;
      flowReg    <= `MSL_RST_FLOW;
      stbyReg    <= `MSL_RST_STBY;
      lineReg    <= `MSL_RST_LINE;
      delimReg   <= `MSL_RST_DELIM;
      sleepReg   <= `MSL_RST_SLEEP;
      timeoutReg <= `MSL_RST_TIMEOUT;
    end
    else if (wrGood)
    begin
      case (regIndex)
        `MSL_IDX_MODE:    modeReg    <= regWrData;
        `MSL_IDX_ADDR:    addrReg    <= regWrData;
        `MSL_IDX_FRAME:   frameReg   <= regWrData;
        `MSL_IDX_FLOW:    flowReg    <= regWrData;
        `MSL_IDX_STBY:    stbyReg    <= regWrData;
        `MSL_IDX_LINE:    lineReg    <= regWrData;
        `MSL_IDX_DELIM:   delimReg   <= regWrData;
        `MSL_IDX_SLEEP:   sleepReg   <= regWrData;
        `MSL_IDX_TIMEOUT: timeoutReg <= regWrData;
        default:          modeReg    <= modeReg;
      endcase
    end
  end

  // Write answer and read data, one cycle after the strobe
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      writeOk       <= 1'b0;
      errorResponse <= 1'b0;
      regRdData     <= 8'h00;
    end
    else
    begin
      writeOk       <= wrGood;
      errorResponse <= regWrite && !writeValid(regIndex, regWrData);
      if (regRead)
      begin
        case (regIndex)
          `MSL_IDX_MODE:    regRdData <= modeReg;
          `MSL_IDX_ADDR:    regRdData <= addrReg;
          `MSL_IDX_FRAME:   regRdData <= frameReg;
          `MSL_IDX_FLOW:    regRdData <= flowReg;
          `MSL_IDX_STBY:    regRdData <= stbyReg;
          `MSL_IDX_LINE:    regRdData <= lineReg;
          `MSL_IDX_DELIM:   regRdData <= delimReg;
          `MSL_IDX_SLEEP:   regRdData <= sleepReg;
          `MSL_IDX_TIMEOUT: regRdData <= timeoutReg;
          default:          regRdData <= 8'h00;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Decoded configuration outputs
  //--------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataBits7         <= 1'b0;
      parityEnable      <= 1'b0;
      parityOdd         <= 1'b0;
      stopBits2         <= 1'b0;
      baudDivisor       <= DIV0;
      flowControlEnable <= 1'b0;
      headerlessMode    <= 1'b0;
      appendCrLf        <= 1'b0;
      delimCrLf         <= 1'b1;
    end
    else
    begin
      dataBits7         <= frameReg[`MSL_B_DATA7];
      parityEnable      <= frameReg[`MSL_B_PAREN];
      parityOdd         <= frameReg[`MSL_B_PARODD];
      stopBits2         <= frameReg[`MSL_B_STOP2];
      case (frameReg[`MSL_B_BAUDHI:`MSL_B_BAUDLO])
        2'h0:    baudDivisor <= DIV0;
        2'h1:    baudDivisor <= DIV1;
        2'h2:    baudDivisor <= DIV2;
        default: baudDivisor <= DIV3;
      endcase
      flowControlEnable <= flowReg[`MSL_B_FLOW];
      headerlessMode    <= (modeReg == `MSL_MODE_HDRLESS);
      appendCrLf        <= (modeReg == `MSL_MODE_HDRLESS) &&
                           lineReg[`MSL_B_CRLF];
      delimCrLf         <= delimReg[`MSL_B_DELIM];
    end
  end

  //--------------------------------------------------------------------
  // Packet filter
  //--------------------------------------------------------------------
  wire        destChk = addrReg[`MSL_B_DESTCHK];
  wire        grpChk  = addrReg[`MSL_B_GRPCHK] && !destChk;
  wire        destHit = destChk && pktDestMatch && !pktBroadcast;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pktAccept <= 1'b0;
      pktAck    <= 1'b0;
    end
    else
    begin
      if (destChk)
        pktAccept <= pktValid && (pktDestMatch || pktBroadcast);
      else if (grpChk)
        pktAccept <= pktValid && pktGroupMatch;
      else
        pktAccept <= pktValid;
      pktAck <= pktValid && destHit;
    end
  end

  //--------------------------------------------------------------------
  // Millisecond tick
  //--------------------------------------------------------------------
  reg  [15:0] msPre;
  wire        msTick = (msPre == MS_LAST);

  // Restarted on each host byte so the idle count starts at the byte
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      msPre <= 16'h0000;
    else if (msTick || hostByteIn)
      msPre <= 16'h0000;
    else
      msPre <= msPre + 16'h0001;
  end

  //--------------------------------------------------------------------
  // Idle timeout flush
  //--------------------------------------------------------------------
  reg  [15:0] idleMs;
  reg         idleDone;
  wire [15:0] toUnit   = delimReg[`MSL_B_TOUNIT] ? `MSL_TO_UNIT1_MS : `MSL_TO_UNIT0_MS;
  wire [15:0] toRaw    = {8'h00, timeoutReg} * toUnit;
  wire [15:0] toTarget = (toRaw < `MSL_TO_MIN_MS) ? `MSL_TO_MIN_MS : toRaw;
  wire        toArmed  = (modeReg == `MSL_MODE_HDRLESS) && !delimReg[`MSL_B_DELIM];

  // One flush per idle gap; a further byte rearms it
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idleMs    <= 16'h0000;
      idleDone  <= 1'b0;
      idleFlush <= 1'b0;
    end
    else
    begin
      idleFlush <= 1'b0;
      if (hostByteIn || !toArmed)
      begin
        idleMs   <= 16'h0000;
        idleDone <= 1'b0;
      end
      else if (!idleDone && idleMs >= toTarget && txBufNonEmpty)
      begin
        idleFlush <= 1'b1;
        idleDone  <= 1'b1;
      end
      else if (msTick && idleMs != 16'hffff)
        idleMs <= idleMs + 16'h0001;
    end
  end

  //--------------------------------------------------------------------
  // Low-power standby and sleep sequencing
  //--------------------------------------------------------------------
  reg         lpBoot;
  reg         lpCmd;
  reg  [1:0]  pwrState;
  reg  [15:0] pwrMs;
  reg  [15:0] stbyTarget;
  wire        lpActive = lpBoot || lpCmd;
  wire [15:0] extMs    = {12'h000, flowReg[`MSL_B_EXTHI:`MSL_B_EXTLO]} *
                         `MSL_EXT_UNIT_MS;
  wire [15:0] stbyMs   = {8'h00, stbyReg} * `MSL_STBY_UNIT_MS;
  wire [15:0] slpUnit  = delimReg[`MSL_B_SLPUNIT] ? `MSL_SLP_UNIT1_MS : `MSL_SLP_UNIT0_MS;
  wire [15:0] slpCfg   = {8'h00, sleepReg} * slpUnit;
  wire [15:0] slpDef   = {8'h00, `MSL_RST_SLEEP} * `MSL_SLP_UNIT0_MS;
  wire [15:0] slpMs    = lpCmd ? slpCfg : slpDef;

  // Mode bit is sampled only on restart or power-down return
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lpBoot <= 1'b0;
      lpCmd  <= 1'b0;
    end
    else
    begin
      if (restartCommand || powerDownReturn)
        lpBoot <= flowReg[`MSL_B_LOWPWR];
      if (standbyEnableCommand)
        lpCmd <= 1'b1;
      else if (standbyReleaseCommand)
        lpCmd <= 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwrState   <= ST_AWAKE;
      pwrMs      <= 16'h0000;
      stbyTarget <= 16'h0000;
    end
    else if (!lpActive)
    begin
      pwrState <= ST_AWAKE;
      pwrMs    <= 16'h0000;
    end
    else
    begin
      case (pwrState)
        ST_AWAKE:
        begin
          pwrState   <= ST_STBY;
          pwrMs      <= 16'h0000;
          stbyTarget <= stbyMs;
        end
        ST_STBY:
        begin
          if (ackSent && extMs == 16'h0000)
          begin
            pwrState <= ST_SLEEP;
            pwrMs    <= 16'h0000;
          end
          else if (pktValid && destHit)
            stbyTarget <= stbyTarget + extMs;
          else if (pwrMs >= stbyTarget)
          begin
            pwrState <= ST_SLEEP;
            pwrMs    <= 16'h0000;
          end
          else if (msTick)
            pwrMs <= pwrMs + 16'h0001;
        end
        ST_SLEEP:
        begin
          if (pwrMs >= slpMs)
          begin
            pwrState   <= ST_STBY;
            pwrMs      <= 16'h0000;
            stbyTarget <= stbyMs;
          end
          else if (msTick)
            pwrMs <= pwrMs + 16'h0001;
        end
        default:
          pwrState <= ST_AWAKE;
      endcase
    end
  end

  // State flags from flip-flops
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inStandby <= 1'b0;
      inSleep   <= 1'b0;
    end
    else
    begin
      inStandby <= lpActive && (pwrState == ST_STBY);
      inSleep   <= lpActive && (pwrState == ST_SLEEP);
    end
  end

endmodule

// *** pkg/msl_consts.vh ***
// Constants of the modem serial-link configuration bank.
// Assumes a single 25 MHz clock and registers addressed by their printed number.
`ifndef MSL_CONSTS_VH
`define MSL_CONSTS_VH

// Register numbers
`define MSL_IDX_MODE      8'h03
`define MSL_IDX_ADDR      8'h12
`define MSL_IDX_FRAME     8'h14
`define MSL_IDX_FLOW      8'h15
`define MSL_IDX_STBY      8'h16
`define MSL_IDX_LINE      8'h17
`define MSL_IDX_DELIM     8'h18
`define MSL_IDX_SLEEP     8'h19
`define MSL_IDX_TIMEOUT   8'h1a

// Reset values
`define MSL_RST_MODE      8'hf0
`define MSL_RST_ADDR      8'h03
`define MSL_RST_FRAME     8'h00
`define MSL_RST_FLOW      8'h09
`define MSL_RST_STBY      8'h04
`define MSL_RST_LINE      8'h00
`define MSL_RST_DELIM     8'hc1
`define MSL_RST_SLEEP     8'h04
`define MSL_RST_TIMEOUT   8'h01

// Mode codes
`define MSL_MODE_PACKET   8'hf0
`define MSL_MODE_HDRLESS  8'hff

// Field positions
`define MSL_B_DESTCHK     0
`define MSL_B_GRPCHK      1
`define MSL_B_DATA7       7
`define MSL_B_PAREN       6
`define MSL_B_PARODD      5
`define MSL_B_STOP2       4
`define MSL_B_BAUDHI      1
`define MSL_B_BAUDLO      0
`define MSL_B_EXTHI       7
`define MSL_B_EXTLO       4
`define MSL_B_LOWPWR      2
`define MSL_B_FLOW        1
`define MSL_B_CRLF        4
`define MSL_B_DELIM       6
`define MSL_B_SLPUNIT     1
`define MSL_B_TOUNIT      0

// Timing
`define MSL_CLK_HZ        25000000
`define MSL_TICK_MS       1
`define MSL_CYC_PER_MS    (`MSL_CLK_HZ / 1000 * `MSL_TICK_MS)
`define MSL_EXT_UNIT_MS   16'd20
`define MSL_STBY_UNIT_MS  16'd10
`define MSL_SLP_UNIT0_MS  16'd10
`define MSL_SLP_UNIT1_MS  16'd100
`define MSL_TO_UNIT0_MS   16'd1
`define MSL_TO_UNIT1_MS   16'd10
`define MSL_TO_MIN_MS     16'd3

// Baud rates
`define MSL_BAUD0         9600
`define MSL_BAUD1         19200
`define MSL_BAUD2         38400
`define MSL_BAUD3         115200

`endif

// *** verif/msl_config_chk.sv ***
// Port-level checker of the modem configuration bank.
// Assumes only the bank's own ports; bound into every bank instance.
`timescale 1ns/1ps
module msl_config_chk
#(
  parameter MS_CYCLES = 10
)
(
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_b,
  // Register and command side
  input wire        regWrite,
  input wire [7:0]  regIndex,
  input wire [7:0]  regWrData,
  input wire        writeOk,
  input wire        errorResponse,
  input wire        standbyEnableCommand,
  // Packets
  input wire        pktValid,
  input wire        pktDestMatch,
  input wire        pktBroadcast,
  input wire        pktAccept,
  input wire        pktAck,
  // Decoded outputs and host byte strobe
  input wire [15:0] baudDivisor,
  input wire        hostByteIn,
  input wire        headerlessMode,
  input wire        appendCrLf,
  input wire        delimCrLf,
  input wire        idleFlush,
  input wire        inStandby,
  input wire        inSleep
);
  reg [15:0] idleCnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Idle gap counter
  // ----------------------------------------
  // Saturates, so a long gap never wraps into a false short one
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      idleCnt <= 16'h0000;
    else if (hostByteIn)
      idleCnt <= 16'h0000;
    else if (idleCnt != 16'hffff)
      idleCnt <= idleCnt + 16'h0001;
  end

  AST_WRITE_ANSWER: assert property (regWrite |=> writeOk != errorResponse)
    else $error("write not answered once");
  AST_NO_STRAY_ANSWER: assert property ((writeOk || errorResponse) |-> $past(regWrite))
    else $error("answer without write");
  AST_ZERO_REFUSED: assert property (regWrite && regWrData == 8'h00 && (regIndex == 8'h16
    || regIndex == 8'h19 || regIndex == 8'h1a) |=> errorResponse) else $error("zero taken");
  AST_MODE_REFUSED: assert property (regWrite && regIndex == 8'h03 && regWrData != 8'hf0
    && regWrData != 8'hff |=> errorResponse) else $error("bad mode taken");
  AST_ACK_CAUSE: assert property (pktAck |-> pktAccept
    && $past(pktValid && pktDestMatch && !pktBroadcast)) else $error("ack without match");
  AST_ACCEPT_CAUSE: assert property (pktAccept |-> $past(pktValid))
    else $error("accept without packet");
  AST_BAUD_SET: assert property (baudDivisor == 16'd2604 || baudDivisor == 16'd1302
    || baudDivisor == 16'd651 || baudDivisor == 16'd217) else $error("baud divisor");
  AST_APPEND_MODE: assert property (appendCrLf |-> headerlessMode)
    else $error("append outside headerless");
  AST_FLUSH_MODE: assert property (idleFlush |-> (headerlessMode && !delimCrLf) ##1 !idleFlush)
    else $error("flush mode or width");
  AST_FLUSH_GAP: assert property (idleFlush |-> idleCnt >= 3 * MS_CYCLES - 2)
    else $error("flush before minimum gap");
  AST_STBY_ENTRY: assert property (standbyEnableCommand |-> ##[1:3] (inStandby || inSleep))
    else $error("standby not entered");
  AST_POWER_EXCL: assert property (!(inStandby && inSleep))
    else $error("standby and sleep together");
endmodule

bind msl_config_bank msl_config_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .regWrite(regWrite), .regIndex(regIndex),
  .regWrData(regWrData), .writeOk(writeOk), .errorResponse(errorResponse),
  .standbyEnableCommand(standbyEnableCommand), .pktValid(pktValid),
  .pktDestMatch(pktDestMatch), .pktBroadcast(pktBroadcast), .pktAccept(pktAccept),
  .pktAck(pktAck), .baudDivisor(baudDivisor), .hostByteIn(hostByteIn),
  .headerlessMode(headerlessMode), .appendCrLf(appendCrLf), .delimCrLf(delimCrLf),
  .idleFlush(idleFlush), .inStandby(inStandby), .inSleep(inSleep)
);

// *** verif/msl_host_model.sv ***
// Host model: register writes, reads and power commands over the parser side.
// Assumes the bank samples every request on the rising edge of ref_clk.
`timescale 1ns/1ps
module msl_host_model
(
  // Clock and read data
  input wire       ref_clk,
  input wire [7:0] regRdData,
  // Requests
  output reg       regWrite,
  output reg       regRead,
  output reg [7:0] regIndex,
  output reg [7:0] regWrData,
  output reg [3:0] cmdPulse,
  output reg       hostFlow
);
  initial
  begin
    {regWrite, regRead, regIndex, regWrData, cmdPulse, hostFlow} = '0;
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // Data inverted after the strobe, so nobody can lean on a stale value
  task wr(input [7:0] idx, input [7:0] d);
  begin
    @(posedge ref_clk);
    regWrite  <= 1'b1;
    regIndex  <= idx;
    regWrData <= d;
    if (idx == 8'h15)
      hostFlow <= d[1];
    @(posedge ref_clk);
    regWrite  <= 1'b0;
    regWrData <= ~d;
  end
  endtask

  task rd(input [7:0] idx, output [7:0] q);
  begin
    @(posedge ref_clk);
    regRead  <= 1'b1;
    regIndex <= idx;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    q = regRdData;
  end
  endtask

  // One-cycle command pulse: enable, release, restart, power-down return
  task cmd(input [1:0] k);
  begin
    @(posedge ref_clk);
    cmdPulse <= 4'h1 << k;
    @(posedge ref_clk);
    cmdPulse <= 4'h0;
  end
  endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the modem configuration bank.
// Assumes the host model on the parser side; packet and byte events come from here.
`timescale 1ns/1ps
module tb_top;
  reg         ref_clk;
  reg         rst_b;
  reg         pktValid;
  reg  [2:0]  pktKind;
  reg         ackSent;
  reg         hostByteIn;
  reg         txBufNonEmpty;
  wire        regWrite, regRead, writeOk, errorResponse, pktAccept, pktAck, hostFlow;
  wire [7:0]  regIndex, regWrData, regRdData;
  wire [3:0]  cmdPulse;
  wire [15:0] baudDivisor;
  wire        dataBits7, parityEnable, parityOdd, stopBits2, flowControlEnable;
  wire        headerlessMode, appendCrLf, delimCrLf, idleFlush, inStandby, inSleep;
  integer     mismatches, check_count, cyc, i, j, n;
  reg  [31:0] rnd;
  reg  [7:0]  q;
  reg  [3:0]  ex, top;
  reg  [3:0]  expQ[$];

  msl_config_bank #(.MS_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .regWrite(regWrite), .regRead(regRead), .regIndex(regIndex), .regWrData(regWrData),
    .regRdData(regRdData), .writeOk(writeOk), .errorResponse(errorResponse),
    .standbyEnableCommand(cmdPulse[0]), .standbyReleaseCommand(cmdPulse[1]),
    .restartCommand(cmdPulse[2]), .powerDownReturn(cmdPulse[3]), .pktValid(pktValid),
    .pktDestMatch(pktKind[2]), .pktGroupMatch(pktKind[1]), .pktBroadcast(pktKind[0]),
    .ackSent(ackSent), .pktAccept(pktAccept), .pktAck(pktAck), .dataBits7(dataBits7),
    .parityEnable(parityEnable), .parityOdd(parityOdd), .stopBits2(stopBits2),
    .baudDivisor(baudDivisor), .flowControlEnable(flowControlEnable),
    .hostByteIn(hostByteIn), .txBufNonEmpty(txBufNonEmpty), .headerlessMode(headerlessMode),
    .appendCrLf(appendCrLf), .delimCrLf(delimCrLf), .idleFlush(idleFlush),
    .inStandby(inStandby), .inSleep(inSleep));
  msl_host_model i_host (.ref_clk(ref_clk), .regRdData(regRdData), .regWrite(regWrite),
    .regRead(regRead), .regIndex(regIndex), .regWrData(regWrData), .cmdPulse(cmdPulse),
    .hostFlow(hostFlow));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function [15:0] bdiv(input [1:0] c);
    bdiv = 16'(25000000 / (c == 0 ? 9600 : c == 1 ? 19200 : c == 2 ? 38400 : 115200));
  endfunction

  function probe(input [1:0] s);
    probe = (s == 0) ? inStandby : (s == 1) ? inSleep : idleFlush;
  endfunction

  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    check_count = check_count + 1;
    if (e !== g)
    begin
      mismatches = mismatches + 1;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  end
  endtask

  // Notes the answer first, so the monitor never sees it before the note
  task w(input [7:0] idx, input [7:0] d, input ok);
  begin
    expQ.push_back(ok ? 4'h8 : 4'h4);
    i_host.wr(idx, d);
  end
  endtask

  task rdchk(input [7:0] idx, input [7:0] e);
  begin
    i_host.rd(idx, q);
    chk("register", {8'h00, e}, {8'h00, q});
  end
  endtask

  // Bounded wait; the count must land inside the window
  task measure(input [1:0] s, input integer lo, input integer hi);
  begin
    n = 0;
    while (probe(s) !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    chk("wait window", 16'h0001, {15'h0000, n >= lo && n <= hi});
  end
  endtask

  task flush(input integer lo, input integer hi);
  begin
    @(posedge ref_clk);
    hostByteIn <= 1'b1;
    @(posedge ref_clk);
    hostByteIn <= 1'b0;
    measure(2, lo, hi);
  end
  endtask

  task summarize;
  begin
    if (expQ.size() != 0)
      mismatches = mismatches + 1;
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // Answer monitor: every write or packet answer must match the oldest note
  always @(posedge ref_clk)
  begin
    if ((writeOk | errorResponse | pktAccept | pktAck) === 1'b1)
    begin
      top = (expQ.size() > 0) ? expQ.pop_front() : 4'hx;
      chk("answer", {12'h000, top}, {12'h000, writeOk, errorResponse, pktAccept, pktAck});
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the roughly 1900 cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  initial
  begin
    {rst_b, pktValid, pktKind, ackSent, hostByteIn, txBufNonEmpty} = '0;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    rnd = 32'h82ed;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdchk(8'h03, 8'hf0);
    rdchk(8'h12, 8'h03);
    rdchk(8'h14, 8'h00);
    rdchk(8'h15, 8'h09);
    rdchk(8'h16, 8'h04);
    rdchk(8'h17, 8'h00);
    rdchk(8'h18, 8'hc1);
    rdchk(8'h19, 8'h04);
    rdchk(8'h1a, 8'h01);
    chk("baud", 16'd2604, baudDivisor);
    w(8'h03, 8'h55, 0);
    w(8'h16, 8'h00, 0);
    w(8'h19, 8'h00, 0);
    w(8'h1a, 8'h00, 0);
    w(8'h20, 8'h12, 0);
    rdchk(8'h1a, 8'h01);
    w(8'h16, 8'hff, 1);
    rdchk(8'h16, 8'hff);
    // Random frame settings, every rate code twice
    for (i = 0; i < 8; i = i + 1)
    begin
      rnd = lfsr(rnd);
      q = {rnd[7:2], i[1:0]};
      w(8'h14, q, 1);
      repeat (2) @(posedge ref_clk);
      chk("frame", {12'h000, q[7:4]}, {12'h000, dataBits7, parityEnable, parityOdd, stopBits2});
      chk("baud", bdiv(q[1:0]), baudDivisor);
    end
    w(8'h15, 8'h0b, 1);
    repeat (2) @(posedge ref_clk);
    chk("flow", {15'h0000, hostFlow}, {15'h0000, flowControlEnable});
    // All filter settings against all packet kinds, one idle cycle apart
    for (i = 0; i < 4; i = i + 1)
    begin
      w(8'h12, i[7:0], 1);
      for (j = 0; j < 8; j = j + 1)
      begin
        ex = {2'b00, i[0] ? (j[2] | j[0]) : (i[1] ? j[1] : 1'b1), i[0] & j[2] & ~j[0]};
        if (ex != 4'h0)
          expQ.push_back(ex);
        @(posedge ref_clk);
        pktValid <= 1'b1;
        pktKind  <= j[2:0];
        @(posedge ref_clk);
        pktValid <= 1'b0;
        pktKind  <= ~j[2:0];
      end
    end
    w(8'h03, 8'hff, 1);
    w(8'h17, 8'h10, 1);
    w(8'h18, 8'h00, 1);
    repeat (2) @(posedge ref_clk);
    chk("headerless", 16'h0006, {13'h0000, headerlessMode, appendCrLf, delimCrLf});
    txBufNonEmpty <= 1'b1;
    flush(27, 34);
    w(8'h1a, 8'h05, 1);
    flush(47, 54);
    w(8'h18, 8'h01, 1);
    flush(497, 504);
    w(8'h03, 8'hf0, 1);
    repeat (2) @(posedge ref_clk);
    chk("append", 16'h0000, {15'h0000, appendCrLf});
    // Power cycle: boot latch first, then the standby-enable command
    w(8'h16, 8'h01, 1);
    w(8'h19, 8'h01, 1);
    w(8'h15, 8'h04, 1);
    i_host.cmd(3);
    measure(0, 1, 4);
    // The millisecond prescaler, restarted only by host bytes, leaves up to one tick of slack here
    measure(1, 91, 102);
    measure(0, 397, 404);
    i_host.cmd(0);
    measure(1, 90, 104);
    measure(0, 97, 104);
    @(posedge ref_clk);
    ackSent <= 1'b1;
    @(posedge ref_clk);
    ackSent <= 1'b0;
    measure(1, 0, 3);
    // One matching packet in standby adds a 20 ms step to the 10 ms stay
    w(8'h15, 8'h14, 1);
    measure(0, 88, 100);
    expQ.push_back(4'h3);
    @(posedge ref_clk);
    pktValid <= 1'b1;
    pktKind  <= 3'h4;
    @(posedge ref_clk);
    pktValid <= 1'b0;
    measure(1, 292, 302);
    i_host.cmd(1);
    i_host.cmd(2);
    summarize;
  end
endmodule
